/* File: logic/vme_voice_mod_engine.sv */
`timescale 1ns/1ps
// Summary of operation
// - Twenty-four routing cords per layer, each one source to one destination.
// - Each cord has a signed amount; negative amounts invert any source but the clock, which they block.
// - Three six-stage rate/level envelopes: two rise, two fall, two key-up.
// - Key press starts envelope from zero toward first rise level; reached levels advance.
// - Without repeat, envelope holds after second fall segment until key release.
// - Key release runs both key-up segments, then the envelope stops.
// - A segment whose level equals the preceding level is skipped.
// - Volume envelope levels are non-negative; filter envelope levels are signed.
// - Auxiliary envelope matches the filter envelope and is a general source.
// - Tempo-based envelopes scale every segment time by the master tempo.
// - Master tempo may come from an external midi clock.
// - Repeat loops the four rise/fall segments while held; release jumps to key-up.
// - Repeat exists only on filter and auxiliary envelopes.
// - Two oscillators per channel, usable as sources for any destination.
// - Random wave differs per voice and layer; pattern waves are identical.
// - Routed clock rising edge retriggers filter and auxiliary envelopes, falling edge retriggers oscillators.
// - Master clock offered in eight divided rates, sixteenth up to octal whole.
// - A clock passes through a cord only when its amount is positive.
// - A clock-triggered oscillator resets its phase to zero when clock goes low.
// - Note-divisor rate locks oscillator to master clock, 25 divisions.
// - Each destination sums all cord contributions algebraically.
// - Gate is high while key held; envelopes follow it.
module vme_voice_mod_engine (
  input  wire logic                      mclk,
  input  wire logic                      rst,
  input  wire logic                      gate,
  input  wire logic [15:0]               voiceSeed,
  input  wire logic [15:0]               tempoCyc,
  input  wire logic                      extTempoSel,
  input  wire logic                      midiClkPulse,
  input  wire logic                      cordWe,
  input  wire logic [4:0]                cordSel,
  input  wire vme_pkg::vme_cord_t        cordIn,
  input  wire logic                      segWe,
  input  wire logic [1:0]                envSel,
  input  wire logic [2:0]                segSel,
  input  wire vme_pkg::vme_seg_t         segIn,
  input  wire logic [2:0]                rptEn,
  input  wire logic [2:0]                tempoEnv,
  input  wire logic [2:0]                envTrigEn,
  input  wire vme_pkg::vme_lfo_cfg_t     lfoCfg [vme_pkg::NLFO],
  input  wire logic [2:0]                srcDivSel,
  input  wire logic [2:0]                trigDivSel,
  input  wire logic signed [7:0]         trigAmt,
  output logic signed [15:0]             envOut [vme_pkg::NENV],
  output vme_pkg::vme_env_st_t           envState [vme_pkg::NENV],
  output logic signed [15:0]             lfoOut [vme_pkg::NLFO],
  output logic [vme_pkg::NDIV-1:0]       divClk,
  output logic                           sampleStart,
  output logic signed [vme_pkg::DSUM_W-1:0] destSum [vme_pkg::NDEST]
);
  vme_pkg::vme_cord_t   cordMem [vme_pkg::NCORD];
  vme_pkg::vme_seg_t    segMem [vme_pkg::NENV][vme_pkg::NSEG];
  logic                 gate_r;
  logic                 gateRise;
  logic                 gateFall;
  logic [15:0]          tempoCnt_r;
  logic [1:0]           midiCnt_r;
  logic                 tick32;
  logic [7:0]           divCnt_r;
  logic [15:0]          envTickCnt_r;
  logic                 envTick;
  logic                 trigLvl;
  logic                 trigLvl_r;
  logic                 trigRise;
  logic                 trigFall;
  logic [4:0]           cordIdx_r;
  logic signed [15:0]   srcVal;
  logic signed [23:0]   prod;
  logic signed [41:0]   scaled;
  logic signed [vme_pkg::DSUM_W-1:0] contrib;
  logic signed [vme_pkg::DSUM_W-1:0] acc_r [vme_pkg::NDEST];
  logic [15:0]          lfoPhase_r [vme_pkg::NLFO];
  logic                 envReach [vme_pkg::NENV];

  assign gateRise = gate & ~gate_r;
  assign gateFall = gate_r & ~gate;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gate_r    <= 1'b0;
      trigLvl_r <= 1'b0;
    end else begin
      gate_r    <= gate;
      trigLvl_r <= trigLvl;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int c = 0; c < vme_pkg::NCORD; c++) cordMem[c] <= '0;
    end else if (cordWe && cordSel < 5'(vme_pkg::NCORD)) begin
      cordMem[cordSel] <= cordIn;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int e = 0; e < vme_pkg::NENV; e++)
        for (int s = 0; s < vme_pkg::NSEG; s++) segMem[e][s] <= '0;
    end else if (segWe && envSel < 2'(vme_pkg::NENV) && segSel < 3'(vme_pkg::NSEG)) begin
      segMem[envSel][segSel] <= segIn;
    end
  end

  // tempo: 32nd-note tick from internal period or from midi clock pulses
  assign tick32 = extTempoSel ?
                  (midiClkPulse && midiCnt_r == 2'(vme_pkg::MIDI_PER_32ND - 1)) :
                  (tempoCnt_r == 16'h0000);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tempoCnt_r <= '0;
      midiCnt_r  <= '0;
    end else begin
      tempoCnt_r <= (tempoCnt_r == 16'h0000) ? tempoCyc : tempoCnt_r - 16'h0001;
      if (midiClkPulse)
        midiCnt_r <= (midiCnt_r == 2'(vme_pkg::MIDI_PER_32ND - 1)) ? 2'h0 : midiCnt_r + 2'h1;
    end
  end

  // bit 0 toggles each 32nd: sixteenth square, up through octal whole at bit 7
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) divCnt_r <= '0;
    else if (tick32) divCnt_r <= divCnt_r + 8'h01;
  end
  assign divClk = divCnt_r;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) envTickCnt_r <= '0;
    else if (envTick) envTickCnt_r <= '0;
    else envTickCnt_r <= envTickCnt_r + 16'h0001;
  end
  assign envTick = envTickCnt_r == 16'(vme_pkg::ENV_TICK_CYC - 1);

  // routed trigger clock, blocked unless its amount is positive
  assign trigLvl  = divClk[trigDivSel] && (trigAmt > 8'sh00);
  assign trigRise = trigLvl & ~trigLvl_r;
  assign trigFall = trigLvl_r & ~trigLvl;
  assign sampleStart = trigRise;

  genvar gi;
  generate
    for (gi = 0; gi < vme_pkg::NENV; gi++) begin : g_env
      localparam bit CAN_RPT = (gi != vme_pkg::ENV_VOL);
      vme_pkg::vme_env_st_t st_r;
      vme_pkg::vme_env_st_t stNxt;
      logic signed [15:0]   val_r;
      logic [2:0]           seg;
      logic signed [7:0]    lvl;
      logic signed [7:0]    prevLvl;
      logic signed [15:0]   tgt;
      logic [15:0]          step;
      logic signed [16:0]   diff;
      logic [16:0]          mag;
      logic                 tick;
      logic                 active;

      always_comb begin
        case (st_r)
          vme_pkg::ST_RISE2:  seg = 3'h1;
          vme_pkg::ST_FALL1:  seg = 3'h2;
          vme_pkg::ST_FALL2:  seg = 3'h3;
          vme_pkg::ST_KEYUP1: seg = 3'h4;
          vme_pkg::ST_KEYUP2: seg = 3'h5;
          default:            seg = 3'h0;
        endcase
      end

      // volume levels clamp at zero; filter and aux keep the sign
      assign lvl = (gi == vme_pkg::ENV_VOL && segMem[gi][seg].level < 8'sh00) ?
                   8'sh00 : segMem[gi][seg].level;
      assign prevLvl = (seg == 3'h0) ? 8'sh00 : segMem[gi][seg - 3'h1].level;
      assign tgt  = {lvl, 8'h00};
      assign step = {4'h0, segMem[gi][seg].rate, 4'h0};
      assign diff = {tgt[15], tgt} - {val_r[15], val_r};
      assign mag  = diff[16] ? -diff : diff;
      assign tick = tempoEnv[gi] ? tick32 : envTick;
      assign envReach[gi] = (segMem[gi][seg].level == prevLvl)
                            || segMem[gi][seg].rate == 8'h00 || mag <= {1'b0, step};
      assign active = st_r != vme_pkg::ST_IDLE && st_r != vme_pkg::ST_KEYUP1
                      && st_r != vme_pkg::ST_KEYUP2;

      always_comb begin
        case (st_r)
          vme_pkg::ST_RISE1:  stNxt = vme_pkg::ST_RISE2;
          vme_pkg::ST_RISE2:  stNxt = vme_pkg::ST_FALL1;
          vme_pkg::ST_FALL1:  stNxt = vme_pkg::ST_FALL2;
          vme_pkg::ST_FALL2:  stNxt = (CAN_RPT && rptEn[gi]) ?
                                      vme_pkg::ST_RISE1 : vme_pkg::ST_HOLD;
          vme_pkg::ST_KEYUP1: stNxt = vme_pkg::ST_KEYUP2;
          vme_pkg::ST_KEYUP2: stNxt = vme_pkg::ST_IDLE;
          default:            stNxt = st_r;
        endcase
      end

      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          st_r  <= vme_pkg::ST_IDLE;
          val_r <= '0;
        end else if (gateFall && active) begin
          st_r <= vme_pkg::ST_KEYUP1;
        end else if (gateRise || (CAN_RPT && envTrigEn[gi] && trigRise && gate)) begin
          st_r  <= vme_pkg::ST_RISE1;
          val_r <= '0;
        end else if (st_r != vme_pkg::ST_IDLE && st_r != vme_pkg::ST_HOLD) begin
          if (envReach[gi]) begin
            val_r <= tgt;
            st_r  <= stNxt;
          end else if (tick) begin
            val_r <= diff[16] ? val_r - step : val_r + step;
          end
        end
      end

      assign envOut[gi]   = val_r;
      assign envState[gi] = st_r;
    end

    for (gi = 0; gi < vme_pkg::NLFO; gi++) begin : g_lfo
      logic [15:0] lfsr_r;
      logic [4:0]  syncCnt_r;
      logic [14:0] tri_w;
      logic        wrap;
      logic        syncHit;
      logic signed [15:0] out_r;

      assign wrap    = ({1'b0, lfoPhase_r[gi]} + {1'b0, lfoCfg[gi].rate}) > 17'h0ffff;
      assign syncHit = tick32 && syncCnt_r == lfoCfg[gi].syncDiv;
      assign tri_w   = lfoPhase_r[gi][15] ? ~lfoPhase_r[gi][14:0] : lfoPhase_r[gi][14:0];

      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          lfoPhase_r[gi] <= '0;
          syncCnt_r      <= '0;
        end else begin
          if (tick32)
            syncCnt_r <= (syncHit || syncCnt_r >= 5'(vme_pkg::NSYNC - 1)) ? 5'h00
                         : syncCnt_r + 5'h01;
          if ((lfoCfg[gi].trigEn && trigFall) || (lfoCfg[gi].syncEn && syncHit))
            lfoPhase_r[gi] <= '0;
          else
            lfoPhase_r[gi] <= lfoPhase_r[gi] + lfoCfg[gi].rate;
        end
      end

      // per-voice seed folded in at key press keeps random waves apart
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) lfsr_r <= 16'h0001;
        else if (gateRise) lfsr_r <= (lfsr_r ^ voiceSeed ^ 16'(gi + 1)) | 16'h0001;
        else lfsr_r <= {1'b0, lfsr_r[15:1]} ^ (lfsr_r[0] ? vme_pkg::LFSR_TAPS : 16'h0000);
      end

      always_ff @(posedge mclk or posedge rst) begin
        if (rst) out_r <= '0;
        else begin
          case (lfoCfg[gi].wave)
            vme_pkg::WAVE_SQR:  out_r <= lfoPhase_r[gi][15] ? vme_pkg::SRC_LOW
                                                            : vme_pkg::SRC_FULL;
            vme_pkg::WAVE_RAND: if (wrap) out_r <= $signed(lfsr_r);
            default:            out_r <= $signed({1'b0, tri_w}) - vme_pkg::TRI_MID;
          endcase
        end
      end
      assign lfoOut[gi] = out_r;
    end
  endgenerate

  // one cord per clock; totals appear once per 24-cycle sweep
  always_comb begin
    case (cordMem[cordIdx_r].src)
      vme_pkg::SRC_GATE: srcVal = gate ? vme_pkg::SRC_FULL : 16'sh0000;
      vme_pkg::SRC_ENV0: srcVal = envOut[0];
      vme_pkg::SRC_ENV1: srcVal = envOut[1];
      vme_pkg::SRC_ENV2: srcVal = envOut[2];
      vme_pkg::SRC_LFO0: srcVal = lfoOut[0];
      vme_pkg::SRC_LFO1: srcVal = lfoOut[1];
      vme_pkg::SRC_CLK:  srcVal = divClk[srcDivSel] ? vme_pkg::SRC_FULL : 16'sh0000;
      default:           srcVal = 16'sh0000;
    endcase
  end

  assign prod   = srcVal * cordMem[cordIdx_r].amt;
  assign scaled = prod * $signed({1'b0, vme_pkg::NORM_MUL});
  assign contrib = (cordMem[cordIdx_r].src == vme_pkg::SRC_CLK
                    && cordMem[cordIdx_r].amt <= 8'sh00) ? '0
                   : scaled[vme_pkg::NORM_SH + vme_pkg::DSUM_W - 1:vme_pkg::NORM_SH];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) cordIdx_r <= '0;
    else cordIdx_r <= (cordIdx_r == 5'(vme_pkg::NCORD - 1)) ? 5'h00 : cordIdx_r + 5'h01;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int d = 0; d < vme_pkg::NDEST; d++) begin
        acc_r[d]   <= '0;
        destSum[d] <= '0;
      end
    end else if (cordIdx_r == 5'(vme_pkg::NCORD - 1)) begin
      for (int d = 0; d < vme_pkg::NDEST; d++) begin
        destSum[d] <= acc_r[d] + ((3'(d) == cordMem[cordIdx_r].dst) ? contrib : '0);
        acc_r[d]   <= '0;
      end
    end else begin
      acc_r[cordMem[cordIdx_r].dst] <= acc_r[cordMem[cordIdx_r].dst] + contrib;
    end
  end

  a_vol_nonneg: assert property (@(posedge mclk) disable iff (rst)
    envOut[vme_pkg::ENV_VOL] >= 16'sh0000) else $error("volume envelope went negative");
  a_keyup_entry: assert property (@(posedge mclk) disable iff (rst)
    ($fell(gate) && envState[0] == vme_pkg::ST_HOLD) |=> envState[0] == vme_pkg::ST_KEYUP1)
    else $error("release did not enter first key-up segment");
  a_start_zero: assert property (@(posedge mclk) disable iff (rst)
    $rose(gate) |=> (envState[0] == vme_pkg::ST_RISE1 && envOut[0] == 16'sh0000))
    else $error("key press did not restart envelope at zero");
  a_vol_holds: assert property (@(posedge mclk) disable iff (rst)
    (envState[0] == vme_pkg::ST_FALL2 && envReach[0] && gate && gate_r)
    |=> envState[0] == vme_pkg::ST_HOLD [*2] or (envState[0] == vme_pkg::ST_HOLD ##1 !gate))
    else $error("volume envelope left hold while key held");
  a_repeat_loop: assert property (@(posedge mclk) disable iff (rst)
    (envState[1] == vme_pkg::ST_FALL2 && envReach[1] && rptEn[1] && gate && gate_r)
    |=> envState[1] == vme_pkg::ST_RISE1) else $error("repeat did not loop to first rise");
  a_clk_block: assert property (@(posedge mclk) disable iff (rst)
    (trigAmt <= 8'sh00) |-> !trigRise) else $error("clock passed a non-positive amount");
  a_lfo_reset: assert property (@(posedge mclk) disable iff (rst)
    (lfoCfg[0].trigEn && trigFall) |=> lfoPhase_r[0] == 16'h0000)
    else $error("oscillator phase not reset on clock low");
  a_div_count: assert property (@(posedge mclk) disable iff (rst)
    tick32 |=> divCnt_r == $past(divCnt_r) + 8'h01) else $error("divider missed a tick");
  a_cord_sweep: assert property (@(posedge mclk) disable iff (rst)
    (cordIdx_r == 5'h00) |-> ##23 cordIdx_r == 5'h17 ##1 cordIdx_r == 5'h00)
    else $error("cord sweep is not 24 cycles");
  a_env_stop: assert property (@(posedge mclk) disable iff (rst)
    (envState[2] == vme_pkg::ST_IDLE && !gate) |=> envState[2] == vme_pkg::ST_IDLE)
    else $error("stopped envelope moved without a key");
endmodule

/* File: logic/vme_pkg.sv */
package vme_pkg;
  localparam int NCORD = 24;
  localparam int NENV  = 3;
  localparam int NLFO  = 2;
  localparam int NDEST = 8;
  localparam int NSEG  = 6;
  localparam int NDIV  = 8;
  localparam int NSYNC = 25;
  localparam int DSUM_W = 21;
  localparam int CLK_NS = 10;
  localparam int ENV_TICK_NS = 10000;
  localparam int ENV_TICK_CYC = (ENV_TICK_NS + CLK_NS - 1) / CLK_NS;
  // midi clock runs at 24 per quarter, so 3 per 32nd
  localparam int MIDI_PER_32ND = 3;
  // 655/65536 ~ 1/100: amount 100 passes the source at full scale
  localparam logic [16:0] NORM_MUL = 17'h0028f;
  localparam int NORM_SH = 16;
  localparam logic signed [15:0] SRC_FULL = 16'sh7fff;
  localparam logic signed [15:0] SRC_LOW  = 16'sh8001;
  localparam logic signed [15:0] TRI_MID  = 16'sh4000;
  localparam int ENV_VOL  = 0;
  localparam int ENV_FILT = 1;
  localparam int ENV_AUX  = 2;
  localparam logic [15:0] LFSR_TAPS = 16'hb400;

  typedef enum logic [3:0] {
    SRC_OFF  = 4'h0,
    SRC_GATE = 4'h1,
    SRC_ENV0 = 4'h2,
    SRC_ENV1 = 4'h3,
    SRC_ENV2 = 4'h4,
    SRC_LFO0 = 4'h5,
    SRC_LFO1 = 4'h6,
    SRC_CLK  = 4'h7
  } vme_src_t;

  typedef enum logic [1:0] {
    WAVE_TRI  = 2'h0,
    WAVE_SQR  = 2'h1,
    WAVE_RAND = 2'h2
  } vme_wave_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_RISE1  = 3'h1,
    ST_RISE2  = 3'h3,
    ST_FALL1  = 3'h2,
    ST_FALL2  = 3'h6,
    ST_HOLD   = 3'h7,
    ST_KEYUP1 = 3'h5,
    ST_KEYUP2 = 3'h4
  } vme_env_st_t;

  typedef struct packed {
    vme_src_t           src;
    logic [2:0]         dst;
    logic signed [7:0]  amt;
  } vme_cord_t;

  typedef struct packed {
    logic signed [7:0]  level;
    logic [7:0]         rate;
  } vme_seg_t;

  typedef struct packed {
    vme_wave_t   wave;
    logic [15:0] rate;
    logic        trigEn;
    logic        syncEn;
    logic [4:0]  syncDiv;
  } vme_lfo_cfg_t;
endpackage

/* File: verif/vme_key_src.sv */
`timescale 1ns/1ps
// keyboard side: a plain level, moved only on the falling edge so the
// engine never sees it change at its own sampling edge
module vme_key_src (
  input  wire logic mclk,
  output logic      gate
);
  initial gate = 1'h0;
  task automatic press();
    @(negedge mclk);
    gate = 1'h1;
  endtask
  task automatic keyUp();
    @(negedge mclk);
    gate = 1'h0;
  endtask
endmodule

/* File: verif/vme_voice_mod_engine_tb.sv */
`timescale 1ns/1ps
module vme_voice_mod_engine_tb;
  logic                          mclk;
  logic                          rst;
  logic                          gate;
  logic                          extTempoSel;
  logic                          midiClkPulse = 1'h0;
  logic                          midiEn;
  logic                          cordWe;
  logic                          segWe;
  logic [15:0]                   voiceSeed;
  logic [15:0]                   tempoCyc;
  logic [4:0]                    cordSel;
  vme_pkg::vme_cord_t            cordIn;
  logic [1:0]                    envSel;
  logic [2:0]                    segSel;
  vme_pkg::vme_seg_t             segIn;
  logic [2:0]                    rptEn;
  logic [2:0]                    tempoEnv;
  logic [2:0]                    envTrigEn;
  logic [2:0]                    srcDivSel;
  logic [2:0]                    trigDivSel;
  vme_pkg::vme_lfo_cfg_t         lfoCfg [vme_pkg::NLFO];
  logic signed [7:0]             trigAmt;
  logic signed [15:0]            envOut [vme_pkg::NENV];
  vme_pkg::vme_env_st_t          envState [vme_pkg::NENV];
  logic signed [15:0]            lfoOut [vme_pkg::NLFO];
  logic [vme_pkg::NDIV-1:0]      divClk;
  logic                          sampleStart;
  logic signed [vme_pkg::DSUM_W-1:0] destSum [vme_pkg::NDEST];
  int                            err_total = 0;
  int                            num_checks = 0;
  int                            n;
  int                            cnt;
  logic signed [15:0]            lv16 [16];
  vme_pkg::vme_env_st_t          stF [6];
  vme_pkg::vme_env_st_t          stV [6];
  int                            evF [6] = '{0, 2560, 2560, -1280, 16384, 2560};
  int                            evV [6] = '{0, 2560, 2560, 0, 16384, 16384};
  logic signed [7:0]             lv [6] = '{8'sh0a, 8'sh0a, -8'sh05, 8'sh40, 8'sh07, 8'sh00};
  logic [7:0]                    rt [6] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};

  vme_key_src KEY (.mclk(mclk), .gate(gate));

  vme_voice_mod_engine DUT (
    .mclk(mclk), .rst(rst), .gate(gate), .voiceSeed(voiceSeed), .tempoCyc(tempoCyc),
    .extTempoSel(extTempoSel), .midiClkPulse(midiClkPulse), .cordWe(cordWe),
    .cordSel(cordSel), .cordIn(cordIn), .segWe(segWe), .envSel(envSel), .segSel(segSel),
    .segIn(segIn), .rptEn(rptEn), .tempoEnv(tempoEnv), .envTrigEn(envTrigEn),
    .lfoCfg(lfoCfg), .srcDivSel(srcDivSel), .trigDivSel(trigDivSel), .trigAmt(trigAmt),
    .envOut(envOut), .envState(envState), .lfoOut(lfoOut), .divClk(divClk),
    .sampleStart(sampleStart), .destSum(destSum)
  );

  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  // two cycles per midi clock, so a 32nd tick every six cycles
  always @(negedge mclk) midiClkPulse <= midiEn & ~midiClkPulse;

  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chkVal(string what, logic signed [31:0] exp, logic signed [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s exp %0d got %0d", what, exp, got);
    end
  endtask
  task automatic chkSt(string what, vme_pkg::vme_env_st_t exp, vme_pkg::vme_env_st_t got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s exp %0d got %0d", what, exp, got);
    end
  endtask
  task automatic wrSeg(int e, int s, logic signed [7:0] l, logic [7:0] r);
    @(negedge mclk);
    segWe = 1'h1;
    envSel = 2'(e);
    segSel = 3'(s);
    segIn = '{level: l, rate: r};
    @(negedge mclk);
    segWe = 1'h0;
  endtask
  task automatic wrCord(int i, vme_pkg::vme_src_t s, int d, int a);
    @(negedge mclk);
    cordWe = 1'h1;
    cordSel = 5'(i);
    cordIn = '{src: s, dst: 3'(d), amt: 8'(a)};
    @(negedge mclk);
    cordWe = 1'h0;
  endtask
  task automatic waitSt(int e, vme_pkg::vme_env_st_t st);
    int k;
    k = 0;
    while (envState[e] !== st && k < 8) begin
      @(negedge mclk);
      k++;
    end
    chkSt("waitSt", st, envState[e]);
  endtask
  task automatic period(int b, output int p);
    logic v;
    p = 0;
    v = divClk[b];
    while (divClk[b] === v && p < 2000) begin
      @(negedge mclk);
      p++;
    end
    v = divClk[b];
    p = 0;
    while (divClk[b] === v && p < 2000) begin
      @(negedge mclk);
      p++;
    end
  endtask
  task automatic gapEnv(output int p);
    logic signed [15:0] v;
    v = envOut[2];
    p = 0;
    while (envOut[2] === v && p < 200) begin
      @(negedge mclk);
      p++;
    end
  endtask
  function automatic int contrib(int s, int a);
    return (s * a * int'(vme_pkg::NORM_MUL)) >>> 16;
  endfunction

  initial begin
    #900000;
    err_total++;
    $display("CHECK FAILED watchdog exp done got hang");
    test_done();
  end

  initial begin
    rst = 1'h1;
    {extTempoSel, midiEn, cordWe, segWe} = 4'h0;
    voiceSeed = 16'h1a2b;
    tempoCyc = 16'h0003;
    cordSel = 5'h00;
    cordIn = '0;
    {envSel, segSel} = 5'h00;
    segIn = '0;
    {rptEn, tempoEnv, envTrigEn, srcDivSel, trigDivSel} = 15'h0000;
    lfoCfg[0] = '0;
    lfoCfg[1] = '0;
    trigAmt = 8'sh00;
    stF = '{vme_pkg::ST_RISE1, vme_pkg::ST_RISE2, vme_pkg::ST_FALL1, vme_pkg::ST_FALL2,
            vme_pkg::ST_RISE1, vme_pkg::ST_RISE2};
    stV = stF;
    stV[4] = vme_pkg::ST_HOLD;
    stV[5] = vme_pkg::ST_HOLD;
    repeat (12) @(posedge mclk);
    chkSt("rstSt", vme_pkg::ST_IDLE, envState[0]);
    chkVal("rstDiv", 0, divClk);
    @(negedge mclk);
    rst = 1'h0;
    // rise2 repeats the rise1 level with a slow rate: the skip and the zero distance left each end it in one cycle
    for (int e = 0; e < 3; e++)
      for (int s = 0; s < 6; s++)
        wrSeg(e, s, lv[s], rt[s]);
    rptEn = 3'h7;
    KEY.press();
    waitSt(1, vme_pkg::ST_RISE1);
    for (int i = 0; i < 6; i++) begin
      if (i > 0)
        @(negedge mclk);
      chkSt("fltSt", stF[i], envState[1]);
      chkVal("fltEnv", evF[i], envOut[1]);
      chkSt("auxSt", stF[i], envState[2]);
      chkVal("auxEnv", evF[i], envOut[2]);
      chkSt("volSt", stV[i], envState[0]);
      chkVal("volEnv", evV[i], envOut[0]);
    end
    wrCord(0, vme_pkg::SRC_ENV0, 0, 100);
    wrCord(23, vme_pkg::SRC_ENV0, 0, -100);
    wrCord(5, vme_pkg::SRC_ENV0, 1, -50);
    wrCord(6, vme_pkg::SRC_ENV0, 1, 100);
    wrCord(24, vme_pkg::SRC_ENV0, 2, 100);
    wrCord(7, vme_pkg::SRC_CLK, 3, -100);
    wrCord(8, vme_pkg::SRC_CLK, 4, 0);
    wrCord(9, vme_pkg::SRC_ENV0, 5, 100);
    wrCord(10, vme_pkg::SRC_GATE, 6, 100);
    repeat (60) @(negedge mclk);
    chkVal("sum0", 0, destSum[0]);
    chkVal("sum1", contrib(16384, -50) + contrib(16384, 100), destSum[1]);
    chkVal("sum2", 0, destSum[2]);
    chkVal("sum3", 0, destSum[3]);
    chkVal("sum4", 0, destSum[4]);
    chkVal("sum5", contrib(16384, 100), destSum[5]);
    chkVal("sum6", contrib(int'(vme_pkg::SRC_FULL), 100), destSum[6]);
    KEY.keyUp();
    waitSt(0, vme_pkg::ST_KEYUP1);
    chkSt("fltUp1", vme_pkg::ST_KEYUP1, envState[1]);
    @(negedge mclk);
    for (int e = 0; e < 3; e++)
      chkVal("up2Env", 1792, envOut[e]);
    @(negedge mclk);
    for (int e = 0; e < 3; e++)
      chkSt("idleSt", vme_pkg::ST_IDLE, envState[e]);
    for (int b = 0; b < 8; b++) begin
      period(b, n);
      chkVal("divPer", 4 << b, n);
    end
    extTempoSel = 1'h1;
    midiEn = 1'h1;
    period(0, n);
    chkVal("midiPer0", 6, n);
    period(1, n);
    chkVal("midiPer1", 12, n);
    extTempoSel = 1'h0;
    midiEn = 1'h0;
    for (int a = 1; a >= -1; a--) begin
      trigAmt = 8'(a);
      repeat (2) @(negedge mclk);
      cnt = 0;
      repeat (64) begin
        @(negedge mclk);
        cnt += int'(sampleStart === 1'h1);
      end
      chkVal("startCnt", (a > 0) ? 8 : 0, cnt);
    end
    trigAmt = 8'sh01;
    lfoCfg[0] = '{wave: vme_pkg::WAVE_TRI, rate: 16'h1234, trigEn: 1'h1,
                  syncEn: 1'h0, syncDiv: 5'h00};
    lfoCfg[1] = lfoCfg[0];
    repeat (20) @(negedge mclk);
    for (int i = 0; i < 16; i++) begin
      lv16[i] = lfoOut[0];
      chkVal("lfoPair", lfoOut[0], lfoOut[1]);
      @(negedge mclk);
    end
    for (int i = 0; i < 8; i++)
      chkVal("lfoTrig", lv16[i], lv16[i + 8]);
    // sync every second 32nd tick: with four-cycle ticks the wave repeats every 8 cycles
    lfoCfg[1].trigEn = 1'h0;
    lfoCfg[1].syncEn = 1'h1;
    lfoCfg[1].syncDiv = 5'h01;
    repeat (20) @(negedge mclk);
    for (int i = 0; i < 16; i++) begin
      lv16[i] = lfoOut[1];
      @(negedge mclk);
    end
    for (int i = 0; i < 8; i++)
      chkVal("lfoSync", lv16[i], lv16[i + 8]);
    // same phase and rate on both layers, so only the random source can split them
    lfoCfg[0] = '{wave: vme_pkg::WAVE_RAND, rate: 16'h4000, trigEn: 1'h1,
                  syncEn: 1'h0, syncDiv: 5'h00};
    lfoCfg[1] = lfoCfg[0];
    repeat (20) @(negedge mclk);
    chkVal("randSplit", 1, int'(lfoOut[0] !== lfoOut[1]));
    tempoEnv = 3'h4;
    wrSeg(2, 0, 8'sh02, 8'h01);
    KEY.press();
    waitSt(2, vme_pkg::ST_RISE1);
    gapEnv(n);
    gapEnv(n);
    chkVal("tmpPer", 4, n);
    chkVal("tmpStep", 32, envOut[2]);
    // volume bit is set too: it must stay in hold while aux restarts
    envTrigEn = 3'h5;
    cnt = 0;
    while (envOut[2] !== 16'sh0000 && cnt < 9) begin
      @(negedge mclk);
      cnt++;
    end
    chkSt("trigSt", vme_pkg::ST_RISE1, envState[2]);
    chkVal("trigEnv", 0, envOut[2]);
    chkSt("volNoTrig", vme_pkg::ST_HOLD, envState[0]);
    KEY.keyUp();
    test_done();
  end
endmodule
